/* shared/thermal_supervisor_pkg.sv */
/*
  Constants, register offsets, field positions and state codes for the
  thermal supervisor. Assumes an APB master with 32-bit data and byte addresses.
*/
package thermal_supervisor_pkg;
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  A_TOP      = 8'h00;
  localparam logic [7:0]  A_CFG      = 8'h04;
  localparam logic [7:0]  A_SEV      = 8'h08;
  localparam logic [7:0]  A_MOD      = 8'h0c;
  localparam logic [7:0]  A_REGU     = 8'h10;
  localparam logic [7:0]  A_MON      = 8'h14;
  localparam logic [7:0]  A_MISC     = 8'h18;
  localparam logic [7:0]  A_START    = 8'h1c;
  localparam logic [7:0]  A_PIN      = 8'h20;
  localparam logic [7:0]  A_FSM      = 8'h24;
  localparam logic [7:0]  A_STAT     = 8'h28;
  // Configuration bits
  localparam int          CFG_LP     = 0;
  localparam int          CFG_SEL    = 1;
  localparam logic [1:0]  CFG_RST    = 2'h0;
  // Comparator bits per detection module
  localparam int          TC_W130    = 0;
  localparam int          TC_W140    = 1;
  localparam int          TC_ORD     = 2;
  localparam int          TC_IMM     = 3;
  localparam int          TC_PER     = 4;
  localparam int          N_MODULE   = 2;
  // Flag fields
  localparam int          SEV_HEAT   = 0;
  localparam int          SEV_W      = 3;
  localparam int          MOD_HEAT   = 0;
  localparam int          MOD_W      = 6;
  localparam int          REG_PER    = 4;
  localparam int          MON_W      = 9;
  localparam int          MISC_ERR   = 0;
  localparam int          MISC_WARN  = 1;
  localparam int          MISC_BUILT_IN_SELF_TEST  = 2;
  localparam int          MISC_CLK   = 3;
  localparam int          MISC_W     = 4;
  localparam int          START_W    = 2;
  // Category summary bits
  localparam int          TOP_SEV    = 0;
  localparam int          TOP_MOD    = 1;
  localparam int          TOP_REGU   = 2;
  localparam int          TOP_MON    = 3;
  localparam int          TOP_MISC   = 4;
  localparam int          TOP_START  = 5;
  localparam int          TOP_PIN    = 6;
  localparam int          TOP_FSM    = 7;
  localparam int          TOP_W      = 8;
  // Status bits
  localparam int          ST_SUP     = 0;
  localparam int          ST_ONE     = 1;
  localparam int          ST_WARN    = 2;
  localparam int          ST_REC_ORD = 3;
  localparam int          ST_REC_IMM = 4;
  localparam int          ST_BLOCK   = 5;
  localparam int          ST_SAFE    = 6;
  typedef enum logic [3:0] {
    S_RUN  = 4'b0001,
    S_ORD  = 4'b0010,
    S_IMM  = 4'b0100,
    S_HOLD = 4'b1000
  } shut_state_t;
endpackage

/* verilog/thermal_supervisor.sv */
/*
  Thermal supervision, shutdown sequencing and grouped interrupt flags with
  an APB register slave. Assumes comparator and pin inputs are asynchronous,
  while error sources, mode levels and sequencer answers come from logic on clk.
*/
// Summary of operation
// - Supervise whenever a regulator runs in mission
// - No supervision in low-power standby
// - Two modules; warning precedes any shutdown
// - Low-power mode, all cool: poll one module
// - Rise in polled module wakes all modules
// - One bit selects the warning threshold
// - Above threshold sets the thermal warning flag
// - Warning decision has no hysteresis
// - Orderly level: flag, moderate error, sequenced off
// - Immediate level first: flag, severe, instant off
// - Record shutdown when switch-off begins
// - No restart until below warning threshold
// - Summary register names the active category
// - Severe group forces instant off, recovery
// - Moderate group forces orderly off, recovery
// - Regulator flags: over/under, short, overcurrent
// - Monitor flags for both inputs and supply
// - Miscellaneous flags never cause shutdown
// - Start-up source flags
// - Rise and fall flags per pin
// - Flag errors that change mission state
// - One active-low interrupt; write one clears
`timescale 1ns/1ps
module thermal_supervisor
  import thermal_supervisor_pkg::*;
#(
  parameter int unsigned N_BUCK = 4,
  parameter int unsigned N_GPIO = 10
) (
  input  wire logic                          clk,               // 25 MHz clock
  input  wire logic                          rst_n,             // Async reset
  input  wire logic                          psel,              // APB select
  input  wire logic                          penable,           // APB enable
  input  wire logic                          pwrite,            // APB direction
  input  wire logic [thermal_supervisor_pkg::ADDR_W-1:0] paddr, // APB address
  input  wire logic [31:0]                   pwdata,            // APB write data
  output logic      [31:0]                   prdata,            // APB read data
  output logic                               pready,            // APB ready
  output logic                               pslverr,           // APB error
  input  wire logic                          mission,           // Mission state
  input  wire logic                          standby,           // Low-power standby
  input  wire logic [N_BUCK-1:0]             buck_en,           // Regulator enables
  input  wire logic [7:0]                    temp_cmp,          // Comparators, async
  input  wire logic                          seq_done,          // Shutdown finished
  input  wire logic                          restart_req,       // Restart request
  input  wire logic [SEV_W-2:0]              severe_src,        // Seq err, supply OV
  input  wire logic [MOD_W-2:0]              moderate_src,      // Moderate sources
  input  wire logic [REG_PER*N_BUCK-1:0]     regulator_src,     // OV,UV,SC,OVERCURRENT_CONDITION each
  input  wire logic [MON_W-1:0]              monitor_src,       // OV,UV,RV x3
  input  wire logic                          wdog_esm_err,      // Watchdog/ESM error
  input  wire logic                          built_in_self_test_pass,         // Self-test passed
  input  wire logic                          ext_clk_ok,        // Sync clock present
  input  wire logic [START_W-1:0]            startup_src,       // First supply, pin
  input  wire logic [N_GPIO-1:0]             gpio_in,           // Pins, async
  output logic [N_MODULE-1:0]                sensor_enable,     // Module enables
  output logic                               moderate_error,    // Moderate pulse
  output logic                               severe_error,      // Severe pulse
  output logic                               orderly_off,       // Sequenced off
  output logic                               immediate_off,     // Instant off
  output logic                               pulldown_en,       // Rail discharge
  output logic                               safe_recovery,     // Recovery state
  output logic                               restart_blocked,   // Too hot to restart
  output logic                               interrupt_out_n    // Interrupt, low
);
  localparam int RW = REG_PER * N_BUCK;
  localparam int PW = 2 * N_GPIO;

  if (N_BUCK < 1 || N_BUCK > 6 || N_GPIO < 1 || N_GPIO > 16) begin : g_chk
    $error("thermal_supervisor: unsupported parameter values");
  end

  typedef struct packed {
    shut_state_t         st;
    logic [7:0]          t_s1;
    logic [7:0]          t_s2;
    logic [N_GPIO-1:0]   g_s1;
    logic [N_GPIO-1:0]   g_s2;
    logic [N_GPIO-1:0]   g_prev;
    logic [1:0]          cfg;
    logic                poll_one;
    logic [N_MODULE-1:0] sens_en;
    logic [SEV_W-1:0]    sev;
    logic [MOD_W-1:0]    mdr;
    logic [RW-1:0]       regu;
    logic [MON_W-1:0]    mon;
    logic [MISC_W-1:0]   misc;
    logic [START_W-1:0]  start;
    logic [PW-1:0]       pin;
    logic                fsm;
    logic [1:0]          rec;
    logic                trip;
    logic                blocked;
    logic                sev_err;
    logic                mod_err;
    logic                int_n;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [N_MODULE-1:0] warn_m;
  logic [N_MODULE-1:0] ord_m;
  logic [N_MODULE-1:0] imm_m;
  logic                active;
  logic                warn;
  logic                ord_t;
  logic                imm_t;
  logic                sev_ev;
  logic                mod_ev;
  logic                wr;
  logic                rd;
  logic                hit;
  logic [31:0]         rdata;
  logic [31:0]         clr;
  logic [TOP_W-1:0]    top;
  logic [31:0]         status;

  always_comb begin
    s_next = s_reg;
    // Two-stage synchronisers
    s_next.t_s1 = temp_cmp;
    s_next.t_s2 = s_reg.t_s1;
    s_next.g_s1 = gpio_in;
    s_next.g_s2 = s_reg.g_s1;
    s_next.g_prev = s_reg.g_s2;

    active = mission & ~standby & (|buck_en);
    for (int k = 0; k < N_MODULE; k++) begin
      warn_m[k] = s_reg.sens_en[k] & (s_reg.cfg[CFG_SEL] ? s_reg.t_s2[TC_PER*k + TC_W140]
                                                         : s_reg.t_s2[TC_PER*k + TC_W130]);
      ord_m[k] = s_reg.sens_en[k] & s_reg.t_s2[TC_PER*k + TC_ORD];
      imm_m[k] = s_reg.sens_en[k] & s_reg.t_s2[TC_PER*k + TC_IMM];
    end
    warn = |warn_m;
    ord_t = active & (|ord_m) & s_reg.st[0];
    imm_t = active & (|imm_m) & ~s_reg.st[3];
    sev_ev = imm_t | ((|severe_src) & ~s_reg.st[3]);
    mod_ev = ord_t | ((|moderate_src) & s_reg.st[0]);

    // Low-power polling of module zero only
    if (!active || !s_reg.cfg[CFG_LP]) begin
      s_next.poll_one = 1'b0;
    end else if (s_reg.poll_one) begin
      s_next.poll_one = ~warn_m[0];
    end else begin
      s_next.poll_one = ~warn;
    end
    s_next.sens_en[0] = active | (s_reg.st[3] & s_reg.trip);
    s_next.sens_en[1] = (active & ~s_next.poll_one) | (s_reg.st[3] & s_reg.trip);

    // Shutdown sequencing
    s_next.sev_err = 1'b0;
    s_next.mod_err = 1'b0;
    case (s_reg.st)
      S_RUN: begin
        if (sev_ev) begin
          s_next.st = S_IMM;
          s_next.sev_err = 1'b1;
        end else if (mod_ev) begin
          s_next.st = S_ORD;
          s_next.mod_err = 1'b1;
        end
      end
      S_ORD: begin
        if (sev_ev) begin
          s_next.st = S_IMM;
          s_next.sev_err = 1'b1;
        end else if (seq_done) begin
          s_next.st = S_HOLD;
        end
      end
      S_IMM: begin
        s_next.st = S_HOLD;
      end
      S_HOLD: begin
        if (restart_req && !(s_reg.trip && warn)) begin
          s_next.st = S_RUN;
          s_next.trip = 1'b0;
        end
      end
      default: begin
        s_next.st = S_HOLD;
      end
    endcase
    s_next.blocked = s_reg.st[3] & s_reg.trip & warn;

    // APB access
    wr = psel & penable & s_reg.pready & pwrite;
    rd = psel & ~penable;
    hit = 1'b1;
    top = '0;
    top[TOP_SEV] = |s_reg.sev;
    top[TOP_MOD] = |s_reg.mdr;
    top[TOP_REGU] = |s_reg.regu;
    top[TOP_MON] = |s_reg.mon;
    top[TOP_MISC] = |s_reg.misc;
    top[TOP_START] = |s_reg.start;
    top[TOP_PIN] = |s_reg.pin;
    top[TOP_FSM] = s_reg.fsm;
    status = '0;
    status[ST_SUP] = active;
    status[ST_ONE] = s_reg.poll_one;
    status[ST_WARN] = warn;
    status[ST_REC_ORD] = s_reg.rec[0];
    status[ST_REC_IMM] = s_reg.rec[1];
    status[ST_BLOCK] = s_reg.blocked;
    status[ST_SAFE] = s_reg.st[3];
    case (paddr)
      A_TOP: rdata = 32'(top);
      A_CFG: rdata = 32'(s_reg.cfg);
      A_SEV: rdata = 32'(s_reg.sev);
      A_MOD: rdata = 32'(s_reg.mdr);
      A_REGU: rdata = 32'(s_reg.regu);
      A_MON: rdata = 32'(s_reg.mon);
      A_MISC: rdata = 32'(s_reg.misc);
      A_START: rdata = 32'(s_reg.start);
      A_PIN: rdata = 32'(s_reg.pin);
      A_FSM: rdata = 32'(s_reg.fsm);
      A_STAT: rdata = status;
      default: begin
        rdata = '0;
        hit = 1'b0;
      end
    endcase
    s_next.pready = rd;
    s_next.pslverr = rd & ~hit;
    if (rd) begin
      s_next.prdata = pwrite ? '0 : rdata;
    end
    if (wr && paddr == A_CFG) begin
      s_next.cfg = pwdata[1:0];
    end

    // Sticky flags: write one clears, a new event wins
    clr = wr ? pwdata : '0;
    s_next.sev = (s_reg.sev & ~(paddr == A_SEV ? clr[SEV_W-1:0] : '0))
               | {severe_src, imm_t & ~s_reg.st[2]};
    s_next.mdr = (s_reg.mdr & ~(paddr == A_MOD ? clr[MOD_W-1:0] : '0))
               | {moderate_src, ord_t};
    s_next.regu = (s_reg.regu & ~(paddr == A_REGU ? clr[RW-1:0] : '0))
                | regulator_src;
    s_next.mon = (s_reg.mon & ~(paddr == A_MON ? clr[MON_W-1:0] : '0))
               | monitor_src;
    s_next.misc = s_reg.misc & ~(paddr == A_MISC ? clr[MISC_W-1:0] : '0);
    s_next.misc[MISC_ERR] = s_next.misc[MISC_ERR] | wdog_esm_err;
    s_next.misc[MISC_WARN] = s_next.misc[MISC_WARN] | (active & warn);
    s_next.misc[MISC_BUILT_IN_SELF_TEST] = s_next.misc[MISC_BUILT_IN_SELF_TEST] | built_in_self_test_pass;
    s_next.misc[MISC_CLK] = s_next.misc[MISC_CLK] | ext_clk_ok;
    s_next.start = (s_reg.start & ~(paddr == A_START ? clr[START_W-1:0] : '0))
                 | startup_src;
    s_next.pin = (s_reg.pin & ~(paddr == A_PIN ? clr[PW-1:0] : '0))
               | {~s_reg.g_s2 & s_reg.g_prev, s_reg.g_s2 & ~s_reg.g_prev};
    s_next.fsm = (s_reg.fsm & ~(paddr == A_FSM && clr[0]))
               | (s_reg.st[0] & (sev_ev | mod_ev));
    s_next.rec = (s_reg.rec & ~(paddr == A_STAT ? clr[ST_REC_IMM:ST_REC_ORD] : 2'h0))
               | {imm_t & ~s_reg.st[2], ord_t & ~sev_ev};
    if (imm_t || ord_t) begin
      s_next.trip = 1'b1;
    end

    s_next.int_n = ~(|{s_next.sev, s_next.mdr, s_next.regu, s_next.mon, s_next.misc,
                       s_next.start, s_next.pin, s_next.fsm});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= S_RUN;
      s_reg.cfg <= CFG_RST;
      s_reg.int_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata          = s_reg.prdata;
  assign pready          = s_reg.pready;
  assign pslverr         = s_reg.pslverr;
  assign sensor_enable   = s_reg.sens_en;
  assign moderate_error  = s_reg.mod_err;
  assign severe_error    = s_reg.sev_err;
  assign orderly_off     = s_reg.st[1];
  assign immediate_off   = s_reg.st[2];
  assign pulldown_en     = s_reg.st[2];
  assign safe_recovery   = s_reg.st[3];
  assign restart_blocked = s_reg.blocked;
  assign interrupt_out_n = s_reg.int_n;
endmodule // thermal_supervisor

/* test/thermal_supervisor_checker.sv */
/*
  Port-level checker for the thermal supervisor, bound into its top module.
  Assumes one clock domain with the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module thermal_supervisor_checker
  import thermal_supervisor_pkg::*;
(
  input wire logic                clk,             // Clock
  input wire logic                rst_n,           // Reset
  input wire logic                standby,         // Standby level
  input wire logic [N_MODULE-1:0] sensor_enable,   // Module enables
  input wire logic                moderate_error,  // Moderate pulse
  input wire logic                severe_error,    // Severe pulse
  input wire logic                orderly_off,     // Sequenced off
  input wire logic                immediate_off,   // Instant off
  input wire logic                pulldown_en,     // Discharge
  input wire logic                safe_recovery,   // Recovery
  input wire logic                restart_blocked, // Restart held
  input wire logic                interrupt_out_n  // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_orderly_entry: assert property ($rose(orderly_off) |-> moderate_error)
    else $error("orderly off without moderate error");
  chk_instant_off: assert property (immediate_off |-> severe_error && pulldown_en)
    else $error("instant off without severe error or discharge");
  chk_instant_recov: assert property (immediate_off |=> !immediate_off && safe_recovery)
    else $error("instant off not followed by recovery");
  chk_error_irq: assert property (moderate_error || severe_error |-> !interrupt_out_n)
    else $error("error without interrupt");
  chk_block_recov: assert property (restart_blocked |-> safe_recovery)
    else $error("restart held outside recovery");
  chk_standby_quiet: assert property (standby && !safe_recovery |=>
    sensor_enable == '0 || safe_recovery)
    else $error("sensors on in standby");
  chk_off_exclusive: assert property (!(orderly_off && immediate_off))
    else $error("both shutdown kinds at once");
  chk_recov_cause: assert property ($rose(safe_recovery) |->
    $past(orderly_off || immediate_off))
    else $error("recovery without shutdown");
  cover property ($rose(orderly_off));
  cover property (immediate_off);
  cover property (restart_blocked);
endmodule // thermal_supervisor_checker

bind thermal_supervisor thermal_supervisor_checker u_chk (.clk(clk), .rst_n(rst_n),
  .standby(standby), .sensor_enable(sensor_enable), .moderate_error(moderate_error),
  .severe_error(severe_error), .orderly_off(orderly_off), .immediate_off(immediate_off),
  .pulldown_en(pulldown_en), .safe_recovery(safe_recovery),
  .restart_blocked(restart_blocked), .interrupt_out_n(interrupt_out_n));

/* test/host_model.sv */
/*
  Host processor model: APB master that reads and clears interrupt flags.
  Assumes a slave that answers with pready.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,     // Clock
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic [7:0]       paddr,   // Address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr  // Error
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // Flags cleared by writing ones; warning select keeps below trip
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Waits for the answer; only the bench watchdog ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule // host_model

/* test/thermal_supervisor_tb.sv */
/*
  Self-checking bench for the thermal supervisor.
  Assumes the host model as bus master and the bound checker.
*/
`timescale 1ns/1ps
module thermal_supervisor_tb;
  import thermal_supervisor_pkg::*;
  logic clk, rst_n, mission, standby, seq_done, restart_req, wdog_esm_err, built_in_self_test_pass;
  logic ext_clk_ok, psel, penable, pwrite, pready, pslverr, interrupt_out_n;
  logic moderate_error, severe_error, orderly_off, immediate_off, pulldown_en;
  logic safe_recovery, restart_blocked;
  logic [7:0] paddr, temp_cmp;
  logic [31:0] pwdata, prdata;
  logic [3:0] buck_en;
  logic [1:0] severe_src, startup_src, sensor_enable;
  logic [4:0] moderate_src;
  logic [15:0] regulator_src;
  logic [8:0] monitor_src;
  logic [9:0] gpio_in;
  int n_mismatch, comparisons;

  host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  thermal_supervisor u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mission(mission), .standby(standby), .buck_en(buck_en),
    .temp_cmp(temp_cmp), .seq_done(seq_done), .restart_req(restart_req),
    .severe_src(severe_src), .moderate_src(moderate_src), .regulator_src(regulator_src),
    .monitor_src(monitor_src), .wdog_esm_err(wdog_esm_err), .built_in_self_test_pass(built_in_self_test_pass),
    .ext_clk_ok(ext_clk_ok), .startup_src(startup_src), .gpio_in(gpio_in),
    .sensor_enable(sensor_enable), .moderate_error(moderate_error),
    .severe_error(severe_error), .orderly_off(orderly_off), .immediate_off(immediate_off),
    .pulldown_en(pulldown_en), .safe_recovery(safe_recovery),
    .restart_blocked(restart_blocked), .interrupt_out_n(interrupt_out_n));

  always #20 clk = ~clk;

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] d;
    logic e;
    u_host.xfer(1'b0, a, '0, d, e);
    cmp(d & m, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    u_host.xfer(1'b1, a, v, d, e);
  endtask
  task automatic clr;
    for (int a = 8; a <= 40; a += 4) wr(8'(a), '1);
  endtask
  // Pulse restart request (1) or sequence done (0)
  task automatic go(input logic r);
    if (r) restart_req <= 1'b1;
    else seq_done <= 1'b1;
    wt(1);
    restart_req <= 1'b0;
    seq_done <= 1'b0;
    wt(2);
  endtask
  task automatic t_base;
    logic [31:0] d;
    logic e;
    ck(A_CFG, 0, '1);
    ck(A_TOP, 0, '1);
    cmp(interrupt_out_n, 1);
    u_host.xfer(1'b0, 8'hfc, '0, d, e);
    cmp(d, 0);
    cmp(e, 1);
    $display("test base done");
  endtask
  task automatic t_sup;
    mission <= 1'b1;
    wt(4);
    ck(A_STAT, 0, 1);
    buck_en <= 4'h8;
    wt(4);
    ck(A_STAT, 1, 1);
    standby <= 1'b1;
    wt(4);
    ck(A_STAT, 0, 1);
    cmp(sensor_enable, 0);
    standby <= 1'b0;
    wr(A_CFG, 1);
    wt(4);
    ck(A_STAT, 2, 2);
    cmp(sensor_enable, 1);
    temp_cmp <= 8'h01;
    wt(6);
    ck(A_STAT, 0, 2);
    cmp(sensor_enable, 3);
    wr(A_CFG, 0);
    $display("test supervision done");
  endtask
  task automatic t_warn;
    temp_cmp <= 8'h00;
    wt(4);
    clr;
    ck(A_MISC, 0, 2);
    temp_cmp <= 8'h10;
    wt(4);
    ck(A_MISC, 2, 2);
    ck(A_STAT, 4, 4);
    wr(A_CFG, 2);
    wt(4);
    ck(A_STAT, 0, 4);
    temp_cmp <= 8'h30;
    wt(4);
    ck(A_STAT, 4, 4);
    temp_cmp <= 8'h10;
    wt(4);
    ck(A_STAT, 0, 4);
    wr(A_CFG, 0);
    temp_cmp <= 8'h00;
    wt(4);
    clr;
    ck(A_TOP, 0, '1);
    cmp(interrupt_out_n, 1);
    $display("test warning done");
  endtask
  task automatic t_heat;
    temp_cmp <= 8'h01;
    wt(4);
    cmp(orderly_off, 0);
    temp_cmp <= 8'h05;
    wt(4);
    cmp(orderly_off, 1);
    ck(A_MOD, 1, 1);
    ck(A_STAT, 8, 8);
    ck(A_FSM, 1, 1);
    ck(A_TOP, 32'h92, '1);
    go(0);
    cmp(safe_recovery, 1);
    go(1);
    cmp({restart_blocked, safe_recovery}, 3);
    temp_cmp <= 8'h00;
    wt(4);
    go(1);
    cmp(safe_recovery, 0);
    clr;
    temp_cmp <= 8'h04;
    wt(4);
    temp_cmp <= 8'h0c;
    for (int i = 0; i < 10 && immediate_off !== 1'b1; i++) @(posedge clk);
    cmp({immediate_off, pulldown_en}, 3);
    wt(1);
    cmp(safe_recovery, 1);
    ck(A_SEV, 1, 1);
    ck(A_STAT, 16, 16);
    temp_cmp <= 8'h00;
    wt(4);
    go(1);
    clr;
    $display("test shutdown done");
  endtask
  task automatic t_err;
    moderate_src <= 5'h10;
    wt(1);
    moderate_src <= 5'h00;
    wt(3);
    cmp(orderly_off, 1);
    go(0);
    go(1);
    cmp(safe_recovery, 0);
    severe_src <= 2'h2;
    wt(1);
    severe_src <= 2'h0;
    wt(3);
    cmp(safe_recovery, 1);
    ck(A_SEV, 4, 4);
    go(1);
    {wdog_esm_err, built_in_self_test_pass, ext_clk_ok} <= 3'h7;
    wt(1);
    {wdog_esm_err, built_in_self_test_pass, ext_clk_ok} <= 3'h0;
    wt(4);
    cmp({orderly_off, safe_recovery}, 0);
    ck(A_MISC, 13, 13);
    clr;
    $display("test errors done");
  endtask
  task automatic t_cat;
    regulator_src <= 16'h8004;
    monitor_src <= 9'h102;
    startup_src <= 2'h3;
    gpio_in <= 10'h200;
    wt(1);
    {regulator_src, monitor_src, startup_src} <= '0;
    wt(5);
    gpio_in <= 10'h000;
    wt(5);
    ck(A_REGU, 32'h8004, '1);
    ck(A_MON, 32'h102, '1);
    ck(A_START, 3, '1);
    ck(A_PIN, 32'h80200, '1);
    ck(A_TOP, 32'h6c, '1);
    clr;
    cmp(interrupt_out_n, 1);
    $display("test categories done");
  endtask
  task automatic close_out;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {clk, rst_n, mission, standby, seq_done, restart_req, buck_en, temp_cmp} = '0;
    {severe_src, moderate_src, regulator_src, monitor_src, startup_src, gpio_in} = '0;
    {wdog_esm_err, built_in_self_test_pass, ext_clk_ok, n_mismatch, comparisons} = '0;
    wt(16);
    rst_n <= 1'b1;
    wt(4);
    t_base;
    t_sup;
    t_warn;
    t_heat;
    t_err;
    t_cat;
    close_out;
  end
  initial begin
    wt(20000);
    n_mismatch++;
    close_out;
  end
endmodule // thermal_supervisor_tb
